// *** core/adc_conversion_sequencer.sv ***
// sequencer, control registers and host port of a 10-bit parallel adc
// ****************************************************************
// Overview of operation
// - hardware start: sample while trigger low
// - software start: 6 sample, 10 convert clocks
// - no read after conversion: auto power-down
// - result valid when completion line falls, or when it rises in end-of-conversion mode
// - capture bus when select and write low
// - end-of-conversion line rises at conversion end
// - hardware internal: oscillator on at trigger rise
// - software start: sampling at write rising edge
// - software start: completion line pulled low
// - software internal: read rise restarts sampling
// - clock source from first register bit 5
// - oscillator starts within half period of trigger
// - oscillator speed from second register bit 6
// - port: data, completion, read, write strobes
// - straight binary or twos complement output
// - completion line high after reset
// - two host-writable control registers
// - select high means software power-down
// - first register bit 7 picks start mode
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic I_CS_N,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic I_CONV_TRIGGER_N,
	input wire logic I_EXT_CLK,
	input wire logic I_EOC_MODE,
	input wire logic [DATA_W-1:0] I_DATA,
	input wire logic [DATA_W-1:0] I_ADC_CODE,
	output logic [DATA_W-1:0] O_DATA,
	output logic O_DATA_OE,
	output logic O_INT_EOC,
	output logic O_SAMPLING,
	output logic O_OSC_RUN,
	output logic O_AUTO_PDOWN,
	output logic O_SW_PDOWN,
	output logic O_OSC_FAST
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [NSYNC-1:0] s3_q;
	logic [NSYNC-1:0] lvl_q;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic trg_n;
	logic eclk;
	logic cs_n_prev_q;
	logic rd_n_prev_q;
	logic wr_n_prev_q;
	logic trg_n_prev_q;
	logic eclk_prev_q;
	assign pin_raw = {I_EXT_CLK, I_CONV_TRIGGER_N, I_WR_N, I_RD_N, I_CS_N};
	// a change counts only once the second and third stages agree
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			s1_q <= 5'h0f;
			s2_q <= 5'h0f;
			s3_q <= 5'h0f;
			lvl_q <= 5'h0f;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
		end
	end
	assign cs_n = lvl_q[0];
	assign rd_n = lvl_q[1];
	assign wr_n = lvl_q[2];
	assign trg_n = lvl_q[3];
	assign eclk = lvl_q[4];
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			cs_n_prev_q <= 1'b1;
			rd_n_prev_q <= 1'b1;
			wr_n_prev_q <= 1'b1;
			trg_n_prev_q <= 1'b1;
			eclk_prev_q <= 1'b1;
		end else begin
			cs_n_prev_q <= cs_n;
			rd_n_prev_q <= rd_n;
			wr_n_prev_q <= wr_n;
			trg_n_prev_q <= trg_n;
			eclk_prev_q <= eclk;
		end
	end
	logic wr_rise;
	logic rd_rise;
	logic trg_fall;
	logic trg_rise;
	logic eclk_rise;
	logic write_cycle;
	logic read_cycle;
	assign wr_rise = wr_n & ~wr_n_prev_q & ~cs_n;
	assign rd_rise = rd_n & ~rd_n_prev_q & ~cs_n;
	assign trg_fall = ~trg_n & trg_n_prev_q;
	assign trg_rise = trg_n & ~trg_n_prev_q;
	assign eclk_rise = eclk & ~eclk_prev_q;
	assign write_cycle = ~cs_n & ~wr_n;
	assign read_cycle = ~cs_n & ~rd_n;
	// ****************************************************************
	// control registers
	// ****************************************************************
	logic [DATA_W-1:0] ctrl_reg_first_q;
	logic [DATA_W-1:0] ctrl_reg_second_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] data_s1_q;
	logic [DATA_W-1:0] data_s2_q;
	logic [DATA_W-1:0] data_s3_q;
	logic [DATA_W-1:0] data_s4_q;
	// bus delayed as far as the strobes, so only words that stood on the
	// pins while select and write were low there are captured
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			data_s1_q <= '0;
			data_s2_q <= '0;
			data_s3_q <= '0;
			data_s4_q <= '0;
		end else begin
			data_s1_q <= I_DATA;
			data_s2_q <= data_s1_q;
			data_s3_q <= data_s2_q;
			data_s4_q <= data_s3_q;
		end
	end
	// data is held while the strobe is low and committed at its rising edge
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			wdata_q <= '0;
		end else if (write_cycle) begin
			wdata_q <= data_s4_q;
		end
	end
	// contents survive power-down; only reset clears them
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_reg_first_q <= CTRL_FIRST_RST;
			ctrl_reg_second_q <= CTRL_SECOND_RST;
		end else if (wr_rise) begin
			if (wdata_q[REG_SEL_BIT]) begin
				ctrl_reg_second_q <= wdata_q;
			end else begin
				ctrl_reg_first_q <= wdata_q;
			end
		end
	end
	logic start_mode_sel;
	logic clock_source_sel;
	logic osc_speed_sel;
	logic output_format_sel;
	assign start_mode_sel = ctrl_reg_first_q[START_MODE_BIT];
	assign clock_source_sel = ctrl_reg_first_q[CLK_SRC_BIT];
	assign osc_speed_sel = ctrl_reg_second_q[OSC_SPEED_BIT];
	assign output_format_sel = ctrl_reg_second_q[FORMAT_BIT];
	// ****************************************************************
	// internal oscillator and core clock tick
	// ****************************************************************
	seq_state_t state_q;
	logic osc_en_q;
	logic [3:0] osc_cnt_q;
	logic osc_tick;
	logic core_tick;
	logic [3:0] div_lim;
	assign div_lim = osc_speed_sel ? 4'(DIV_FAST - 1) : 4'(DIV_SLOW - 1);
	// one tick per period; the sequencer needs no even duty cycle
	assign osc_tick = osc_en_q && osc_cnt_q == div_lim;
	assign core_tick = clock_source_sel ? eclk_rise : osc_tick;
	logic start_hw;
	logic start_sw;
	logic first_wr;
	logic mode_next;
	logic src_next;
	// a write to the first register acts with its new mode and source
	// already at its own rising edge
	assign first_wr = wr_rise & ~wdata_q[REG_SEL_BIT];
	assign mode_next = first_wr ? wdata_q[START_MODE_BIT] : start_mode_sel;
	assign src_next = first_wr ? wdata_q[CLK_SRC_BIT] : clock_source_sel;
	assign start_hw = ~start_mode_sel & trg_rise;
	assign start_sw = mode_next & (wr_rise | rd_rise);
	// oscillator gated on by a hardware or software start and off after each conversion
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			osc_en_q <= 1'b0;
		end else if (state_q == ST_DONE || ~cs_n_prev_q & cs_n) begin
			osc_en_q <= 1'b0;
		end else if (~src_next & (start_hw | start_sw)) begin
			osc_en_q <= 1'b1;
		end
	end
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			osc_cnt_q <= 4'h0;
		end else if (!osc_en_q) begin
			osc_cnt_q <= 4'h0;
		end else if (osc_cnt_q == div_lim) begin
			osc_cnt_q <= 4'h0;
		end else begin
			osc_cnt_q <= osc_cnt_q + 4'h1;
		end
	end
	// ****************************************************************
	// conversion sequence
	// ****************************************************************
	logic [3:0] clk_cnt_q;
	logic [DATA_W-1:0] result_q;
	logic conv_end;
	assign conv_end = state_q == ST_CONV && core_tick
		&& clk_cnt_q == 4'(CONV_CLKS - 1);
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_q <= ST_IDLE;
			clk_cnt_q <= 4'h0;
		end else if (cs_n) begin
			state_q <= ST_PDOWN;
			clk_cnt_q <= 4'h0;
		end else begin
			unique case (state_q)
				ST_IDLE, ST_PDOWN: begin
					clk_cnt_q <= 4'h0;
					if (~start_mode_sel & trg_fall) begin
						state_q <= ST_SAMPLE;
					end else if (start_sw) begin
						state_q <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (~start_mode_sel) begin
						if (trg_rise) begin
							state_q <= ST_CONV;
							clk_cnt_q <= 4'h0;
						end
					end else if (core_tick) begin
						if (clk_cnt_q == 4'(SAMPLE_CLKS - 1)) begin
							state_q <= ST_CONV;
							clk_cnt_q <= 4'h0;
						end else begin
							clk_cnt_q <= clk_cnt_q + 4'h1;
						end
					end
				end
				ST_CONV: begin
					if (conv_end) begin
						state_q <= ST_DONE;
						clk_cnt_q <= 4'h0;
					end else if (core_tick) begin
						clk_cnt_q <= clk_cnt_q + 4'h1;
					end
				end
				ST_DONE: begin
					// one core clock for a read before power-down; one system clock when the oscillator is the source
					if (read_cycle) begin
						state_q <= ST_IDLE;
					end else if (core_tick | osc_tick) begin
						state_q <= ST_PDOWN;
					end else if (~clock_source_sel) begin
						state_q <= ST_PDOWN;
					end
				end
			endcase
		end
	end
	// result latched on the same clock as the completion edge so it is valid there
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			result_q <= '0;
		end else if (conv_end) begin
			result_q <= output_format_sel ? (I_ADC_CODE ^ MID_CODE)
				: I_ADC_CODE;
		end
	end
	// ****************************************************************
	// completion line and bus drive
	// ****************************************************************
	logic int_eoc_q;
	logic int_pend_q;
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			int_eoc_q <= 1'b1;
			int_pend_q <= 1'b0;
		end else if (I_EOC_MODE) begin
			int_pend_q <= 1'b0;
			if (state_q == ST_CONV && !conv_end) begin
				int_eoc_q <= 1'b0;
			end else begin
				int_eoc_q <= 1'b1;
			end
		end else begin
			// set wins over a read clearing it in the same cycle
			if (conv_end) begin
				int_eoc_q <= 1'b0;
				int_pend_q <= 1'b1;
			end else if (int_pend_q & read_cycle) begin
				int_eoc_q <= 1'b1;
				int_pend_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_DATA <= '0;
			O_DATA_OE <= 1'b0;
		end else begin
			O_DATA <= result_q;
			O_DATA_OE <= read_cycle;
		end
	end
	assign O_INT_EOC = int_eoc_q;
	assign O_SAMPLING = state_q == ST_SAMPLE;
	assign O_OSC_RUN = osc_en_q;
	assign O_AUTO_PDOWN = state_q == ST_PDOWN & ~cs_n;
	assign O_SW_PDOWN = cs_n;
	assign O_OSC_FAST = osc_speed_sel;
	// ****************************************************************
	// checks
	// ****************************************************************
	hw_sample_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		state_q == ST_IDLE && !cs_n && !start_mode_sel && trg_fall
		|=> state_q == ST_SAMPLE) else $error("hw sample not started");
	sw_conv_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		state_q == ST_SAMPLE && start_mode_sel && core_tick && !cs_n
		&& clk_cnt_q == 4'h5 |=> state_q == ST_CONV)
		else $error("sample length wrong");
	auto_pdown_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		state_q == ST_DONE && !read_cycle && !cs_n && !clock_source_sel
		|=> state_q == ST_PDOWN) else $error("no auto power-down");
	result_valid_a: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) conv_end |=> result_q == $past(output_format_sel
		? (I_ADC_CODE ^ MID_CODE) : I_ADC_CODE)) else $error("result stale");
	write_cap_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		write_cycle |=> wdata_q == $past(data_s4_q)) else $error("write lost");
	int_low_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		conv_end && !I_EOC_MODE |=> !int_eoc_q) else $error("int not low");
	osc_on_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		!clock_source_sel && start_hw && state_q != ST_DONE && !cs_n
		&& !cs_n_prev_q && !wr_rise
		|=> osc_en_q) else $error("oscillator not started");
	pdown_sw_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		cs_n |=> state_q == ST_PDOWN) else $error("no software power-down");
	bus_drive_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		O_DATA_OE |-> $past(read_cycle)) else $error("bus driven outside read");
endmodule
`default_nettype wire

// *** inc/adc_seq_pkg.sv ***
// shared constants for the conversion sequencer
package adc_seq_pkg;
	localparam int DATA_W = 10;
	localparam int SAMPLE_CLKS = 6;
	localparam int CONV_CLKS = 10;
	localparam int TOTAL_CLKS = 16;
	localparam int START_MODE_BIT = 7;
	localparam int CLK_SRC_BIT = 5;
	localparam int OSC_SPEED_BIT = 6;
	localparam int FORMAT_BIT = 3;
	localparam int REG_SEL_BIT = 8;
	localparam logic [9:0] CTRL_FIRST_RST = 10'h000;
	localparam logic [9:0] CTRL_SECOND_RST = 10'h000;
	localparam logic [9:0] MID_CODE = 10'h200;
	// slow and fast core clock divisors of the 100 MHz system clock
	localparam int SYS_MHZ = 100;
	localparam int OSC_SLOW_MHZ = 10;
	localparam int OSC_FAST_MHZ = 20;
	localparam int DIV_SLOW = SYS_MHZ / OSC_SLOW_MHZ;
	localparam int DIV_FAST = SYS_MHZ / OSC_FAST_MHZ;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SAMPLE = 5'b00010,
		ST_CONV = 5'b00100,
		ST_DONE = 5'b01000,
		ST_PDOWN = 5'b10000
	} seq_state_t;
endpackage

// *** verif/adc_conversion_sequencer_test.sv ***
// self-checking bench of the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer_test;
	import adc_seq_pkg::*;
	logic I_SYS_CLK = 1'b0;
	logic I_RST = 1'b1;
	logic I_EOC_MODE = 1'b0;
	logic [DATA_W-1:0] I_ADC_CODE = 10'h2c5;
	wire logic cs_n, rd_n, wr_n, trig_n, ext_clk;
	wire logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] O_DATA;
	logic O_DATA_OE, O_INT_EOC, O_SAMPLING, O_OSC_RUN;
	logic O_AUTO_PDOWN, O_SW_PDOWN, O_OSC_FAST;
	int miscompares = 0;
	int tests_run = 0;
	int n;
	always #5 I_SYS_CLK = ~I_SYS_CLK;
	adc_host_model host (.i_clk(I_SYS_CLK), .o_cs_n(cs_n), .o_rd_n(rd_n),
		.o_wr_n(wr_n), .o_trig_n(trig_n), .o_ext_clk(ext_clk), .o_data(wdata));
	adc_conversion_sequencer DUT (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
		.I_CS_N(cs_n), .I_RD_N(rd_n), .I_WR_N(wr_n),
		.I_CONV_TRIGGER_N(trig_n), .I_EXT_CLK(ext_clk),
		.I_EOC_MODE(I_EOC_MODE), .I_DATA(wdata), .I_ADC_CODE(I_ADC_CODE),
		.O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE), .O_INT_EOC(O_INT_EOC),
		.O_SAMPLING(O_SAMPLING), .O_OSC_RUN(O_OSC_RUN),
		.O_AUTO_PDOWN(O_AUTO_PDOWN), .O_SW_PDOWN(O_SW_PDOWN),
		.O_OSC_FAST(O_OSC_FAST));
	// ****************************************
	// shared helpers
	// ****************************************
	task check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("compared %0d, mismatched %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	function logic pick(input int sel);
		case (sel)
			0: return O_INT_EOC;
			1: return O_SAMPLING;
			2: return O_OSC_RUN;
			3: return O_AUTO_PDOWN;
			4: return O_SW_PDOWN;
			default: return O_DATA_OE;
		endcase
	endfunction
	// bounded wait; cycles taken are returned for timing checks
	task wait_out(input int sel, input logic v, input int lim);
		n = 0;
		while (pick(sel) !== v) begin
			@(posedge I_SYS_CLK);
			#1;
			n++;
			if (n > lim) begin
				miscompares++;
				$display("mismatch wait %0d expected %h seen timeout", sel, v);
				print_verdict;
			end
		end
	endtask
	task read_check(input logic [DATA_W-1:0] exp);
		host.set_pin(1, 1'b0);
		wait_out(5, 1'b1, 10);
		check("read data", O_DATA, exp);
		wait_out(0, 1'b1, 6);
		host.set_pin(1, 1'b1);
		wait_out(5, 1'b0, 10);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_sw_ext;
		host.set_pin(0, 1'b0);
		wait_out(4, 1'b0, 10);
		host.write_reg(10'h148);
		check("fast osc", O_OSC_FAST, 1'b1);
		host.write_reg(10'h0a0);
		wait_out(1, 1'b1, 20);
		wait_out(1, 1'b0, 80);
		check("sample span ok", n inside {[50:70]}, 1'b1);
		wait_out(0, 1'b0, 130);
		check("convert span ok", n inside {[90:115]}, 1'b1);
		check("osc idle on ext clk", O_OSC_RUN, 1'b0);
		// first result after resume: its whole twos complement value is compared
		read_check(I_ADC_CODE ^ MID_CODE);
		wait_out(0, 1'b0, 250);
		wait_out(3, 1'b1, 20);
	endtask
	task t_hw_ext;
		// mode first, so the second write cannot start a conversion
		host.write_reg(10'h020);
		host.write_reg(10'h140);
		I_EOC_MODE <= 1'b1;
		host.set_pin(2, 1'b0);
		wait_out(1, 1'b1, 10);
		repeat (40) @(posedge I_SYS_CLK);
		check("sampling held", O_SAMPLING, 1'b1);
		host.set_pin(2, 1'b1);
		wait_out(1, 1'b0, 10);
		wait_out(0, 1'b0, 3);
		check("eoc low in conversion", O_INT_EOC, 1'b0);
		wait_out(0, 1'b1, 130);
		check("eoc span ok", n >= 85, 1'b1);
		read_check(I_ADC_CODE);
	endtask
	task t_hw_int;
		host.write_reg(10'h000);
		I_EOC_MODE <= 1'b0;
		I_ADC_CODE <= 10'h13a;
		host.set_pin(2, 1'b0);
		repeat (10) @(posedge I_SYS_CLK);
		host.set_pin(2, 1'b1);
		wait_out(2, 1'b1, 10);
		wait_out(0, 1'b0, 150);
		wait_out(2, 1'b0, 20);
		read_check(10'h13a);
	endtask
	task t_sw_pdown;
		host.set_pin(0, 1'b1);
		wait_out(4, 1'b1, 10);
		check("regs kept", O_OSC_FAST, 1'b1);
	endtask
	initial begin
		repeat (2) @(posedge I_SYS_CLK);
		#1;
		check("int at reset", O_INT_EOC, 1'b1);
		check("oe at reset", O_DATA_OE, 1'b0);
		check("pdown at reset", O_SW_PDOWN, 1'b1);
		@(posedge I_SYS_CLK);
		I_RST <= 1'b0;
		t_sw_ext;
		t_hw_ext;
		t_hw_int;
		t_sw_pdown;
		print_verdict;
	end
endmodule
`default_nettype wire

// *** verif/adc_host_model.sv ***
// host processor model driving the parallel port and the external clock
`timescale 1ns/100ps
`default_nettype none
module adc_host_model
	import adc_seq_pkg::*;
(
	input wire logic i_clk,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_trig_n,
	output logic o_ext_clk,
	output logic [DATA_W-1:0] o_data
);
	// ****************************************
	// external clock, free running
	// ****************************************
	int ph = 0;
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_trig_n = 1'b1;
		o_ext_clk = 1'b0;
		o_data = 10'h155;
	end
	// toggles on the falling system edge so trigger rises never coincide
	always @(negedge i_clk) begin
		ph = (ph == 4) ? 0 : ph + 1;
		if (ph == 0) o_ext_clk <= ~o_ext_clk;
	end
	// ****************************************
	// bus cycles
	// ****************************************
	task set_pin(input int which, input logic v);
		@(posedge i_clk);
		case (which)
			0: o_cs_n <= v;
			1: o_rd_n <= v;
			default: o_trig_n <= v;
		endcase
	endtask
	// released bus shows the inverse so a late capture is visible
	task write_reg(input logic [DATA_W-1:0] v);
		@(posedge i_clk);
		o_data <= v;
		o_wr_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		o_wr_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_data <= ~v;
		// the registers take the word some cycles after the strobe pin
		repeat (4) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire
